// ---- common/lsc_pkg.sv ----
// Package with constants and types for the level-one data cache snoop coherence block
package lsc_pkg;
    localparam int LINE_BYTES   = 64;                 // Line size in bytes
    localparam int OFFSET_BITS  = $clog2(LINE_BYTES);
    localparam int WAYS         = 2;                  // Two-way set associative
    localparam int SETS_DEF     = 16;                 // Default number of sets
    localparam int ADDR_W       = 32;
    localparam int PEND_DEF     = 4;                  // Outstanding snoop slots
    localparam logic [0:0] WAY0 = 1'h0;
    localparam logic [0:0] WAY1 = 1'h1;

    // Level-two partition modes
    typedef enum logic [1:0] {
        LSC_L2_MIXED = 2'b00,
        LSC_L2_CACHE = 2'b01,
        LSC_L2_SRAM  = 2'b10
    } lsc_l2mode_t;
endpackage

// ---- design/lsc_snoop_core.sv ----
// Level-one data cache tag array with snoop-write tracking and cancellation
// Operation
// - External writes to level-two SRAM launch snoop writes into matching level-one lines.
// - Two CPU reads per cycle are accepted while snoop writes are outstanding.
// - A read hitting level-two cache allocates and replaces the victim way.
// - A snoop write already pending when its line is replaced is cancelled; one launched in that same cycle still issues.
// - After replacement the way holds the new level-two cache line plus any snoop write launched in the replacement cycle.
// - Lines are 64 bytes so 64-byte aligned buffers never share a line.
// - Level-two RAM can be all cache or all plain SRAM.
// - Level-one data RAM can be all plain SRAM with caching off.
// - Slave DMA port may target buffers in level-one data RAM.
// - Cache is two-way set associative: two candidate locations per address.
// - Dirty lines are written back only on eviction or software request.
`timescale 1ns/1ps
`default_nettype none
module lsc_snoop_core
    import lsc_pkg::*;
#(
    parameter int SETS = SETS_DEF,
    parameter int PEND = PEND_DEF
) (
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic                clkEn,
    input  wire lsc_l2mode_t         l2Mode,
    input  wire logic                l1SramMode,
    input  wire logic [1:0]          rdValid,
    input  wire logic [2*ADDR_W-1:0] rdAddr,
    input  wire logic [1:0]          rdL2CacheHit,
    output logic [1:0]               rdReady,
    output logic [1:0]               fillValid,
    output logic [1:0]               fillWay,
    input  wire logic                dmaValid,
    input  wire logic [ADDR_W-1:0]   dmaAddr,
    input  wire logic                dmaToL1,
    input  wire logic                dmaL2IsSram,
    output logic                     dmaReady,
    output logic                     dmaL1Access,
    output logic                     snoopValid,
    output logic [$clog2(SETS)-1:0]  snoopSet,
    output logic                     snoopWay,
    input  wire logic                snoopDone,
    output logic                     cancelPulse,
    input  wire logic                wbRequest,
    output logic                     wbValid,
    output logic [ADDR_W-1:0]        wbAddr
);
    localparam int SB = $clog2(SETS);
    localparam int TB = ADDR_W - OFFSET_BITS - SB;
    localparam int PB = $clog2(PEND);

    // Tag state per set and way
    logic [TB-1:0]   tag_q   [SETS][WAYS];
    logic            vld_q   [SETS][WAYS];
    logic            dirty_q [SETS][WAYS];
    logic            lru_q   [SETS];
    // Pending snoop slots
    logic [PEND-1:0] pVld_q, pVld_d;
    logic [SB-1:0]   pSet_q  [PEND];
    logic            pWay_q  [PEND];
    logic [PB-1:0]   head_q, head_d;
    logic [PB-1:0]   tail_q, tail_d;

    logic [SB-1:0] dSet;
    logic [TB-1:0] dTag;
    logic [1:0]    dHit;
    logic          dNeedSnoop, freeAvail;
    logic [PB-1:0] freeIdx;
    logic [SB-1:0] rSet [2];
    logic [TB-1:0] rTag [2];
    logic          rWay [2];
    logic [1:0]    rHit, alloc;
    logic [PEND-1:0] kill;
    logic            wbVld_d;
    logic [ADDR_W-1:0] wbAddr_d;

    // DMA lookup; a level-one target bypasses snooping entirely
    always_comb begin
        dSet = dmaAddr[OFFSET_BITS +: SB];
        dTag = dmaAddr[ADDR_W-1 -: TB];
        for (int w = 0; w < WAYS; w++) begin
            dHit[w] = vld_q[dSet][w] && tag_q[dSet][w] == dTag;
        end
        dmaL1Access = dmaValid && dmaToL1;
        dNeedSnoop  = dmaValid && !dmaToL1 && dmaL2IsSram && (l2Mode != LSC_L2_CACHE)
                      && !l1SramMode && (dHit != 2'h0);
        // Allocate at the tail so ring order stays issue order; a lowest-free pick would not
        freeIdx   = tail_q;
        freeAvail = !pVld_q[tail_q];
        dmaReady = !dNeedSnoop || freeAvail;                                  // Stall when slots full
    end

    // CPU reads: both ports always accepted, misses hitting level-two cache allocate
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            rSet[i] = rdAddr[i*ADDR_W + OFFSET_BITS +: SB];
            rTag[i] = rdAddr[i*ADDR_W + ADDR_W-1 -: TB];
            rHit[i] = (vld_q[rSet[i]][WAY0] && tag_q[rSet[i]][WAY0] == rTag[i])
                   || (vld_q[rSet[i]][WAY1] && tag_q[rSet[i]][WAY1] == rTag[i]);
            rWay[i] = lru_q[rSet[i]];
            alloc[i] = rdValid[i] && !rHit[i] && !l1SramMode;
        end
        // One line missed on both ports is filled once; two ways with one tag would double-hit
        if (alloc[0] && alloc[1] && rSet[0] == rSet[1] && rTag[0] == rTag[1]) begin
            alloc[1] = 1'b0;
        end
        // Same-set double allocation takes the other way for port one
        if (alloc[0] && alloc[1] && rSet[0] == rSet[1]) begin
            rWay[1] = !rWay[0];
        end
        rdReady   = 2'b11;
        fillValid = alloc;
        fillWay   = {rWay[1], rWay[0]};
        // Kill any pending snoop aimed at a line being refilled
        for (int p = 0; p < PEND; p++) begin
            kill[p] = pVld_q[p] && (
                (alloc[0] && pSet_q[p] == rSet[0] && pWay_q[p] == rWay[0]) ||
                (alloc[1] && pSet_q[p] == rSet[1] && pWay_q[p] == rWay[1]));
        end
        cancelPulse = |kill;
        // Victim write-back only when a dirty line is evicted or software asks
        wbVld_d  = 1'b0;
        wbAddr_d = '0;
        for (int i = 1; i >= 0; i--) begin
            if (alloc[i] && vld_q[rSet[i]][rWay[i]] && dirty_q[rSet[i]][rWay[i]]) begin
                wbVld_d  = 1'b1;
                wbAddr_d = {tag_q[rSet[i]][rWay[i]], rSet[i], OFFSET_BITS'(0)};
            end
        end
        if (wbRequest && !wbVld_d) begin
            wbVld_d  = 1'b1;
            wbAddr_d = {dTag, dSet, OFFSET_BITS'(0)};
        end
    end

    // Pending queue next state; completion retires head, kill wins
    always_comb begin
        pVld_d = pVld_q & ~kill;
        head_d = head_q;
        tail_d = tail_q;
        if (snoopValid && snoopDone) begin
            pVld_d[head_q] = 1'b0;
            head_d = head_q + PB'(1);
        end else if (pVld_q == '0) begin
            head_d = tail_q;                                                // Empty: head meets tail
        end else if (!pVld_q[head_q]) begin
            head_d = head_q + PB'(1);                                       // Skip cancelled slot
        end
        if (dNeedSnoop && freeAvail) begin
            pVld_d[freeIdx] = 1'b1;
            tail_d = tail_q + PB'(1);
        end
    end

    // Issue the head slot; cancelled entries never reach the data array
    always_comb begin
        snoopValid = pVld_q[head_q] && !kill[head_q];
        snoopSet   = pSet_q[head_q];
        snoopWay   = pWay_q[head_q];
    end

    // Register everything
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pVld_q <= '0;
            head_q <= '0;
            tail_q <= '0;
            wbValid <= 1'b0;
            wbAddr <= '0;
            for (int s = 0; s < SETS; s++) begin
                lru_q[s] <= 1'b0;
                for (int w = 0; w < WAYS; w++) begin
                    vld_q[s][w]   <= 1'b0;
                    dirty_q[s][w] <= 1'b0;
                    tag_q[s][w]   <= '0;
                end
            end
            for (int p = 0; p < PEND; p++) begin
                pSet_q[p] <= '0;
                pWay_q[p] <= 1'b0;
            end
        end else if (clkEn) begin
            pVld_q  <= pVld_d;
            head_q  <= head_d;
            tail_q  <= tail_d;
            wbValid <= wbVld_d;
            wbAddr  <= wbAddr_d;
            if (dNeedSnoop && freeAvail) begin
                pSet_q[freeIdx] <= dSet;
                pWay_q[freeIdx] <= dHit[1];
            end
            if (wbRequest) begin
                dirty_q[dSet][WAY0] <= 1'b0;
                dirty_q[dSet][WAY1] <= 1'b0;
            end
            if (l1SramMode || l2Mode == LSC_L2_SRAM) begin
                for (int s = 0; s < SETS; s++) begin
                    vld_q[s][WAY0] <= 1'b0;
                    vld_q[s][WAY1] <= 1'b0;
                end
            end else begin
                for (int i = 0; i < 2; i++) begin
                    if (alloc[i] && rdL2CacheHit[i]) begin
                        tag_q[rSet[i]][rWay[i]]   <= rTag[i];
                        vld_q[rSet[i]][rWay[i]]   <= 1'b1;
                        dirty_q[rSet[i]][rWay[i]] <= 1'b0;
                        lru_q[rSet[i]]            <= !rWay[i];
                    end
                end
            end
        end
    end

    a_kill_stops_snoop: assert property (@(posedge clk) disable iff (!reset_n)
        pVld_q[head_q] &&
        ((alloc[0] && pSet_q[head_q] == rSet[0] && pWay_q[head_q] == rWay[0]) ||
         (alloc[1] && pSet_q[head_q] == rSet[1] && pWay_q[head_q] == rWay[1]))
        |-> !snoopValid)
        else $error("cancelled snoop issued");
    a_kill_clears_slot: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && cancelPulse |=> ($past(kill) & pVld_q) == '0)
        else $error("cancelled slot still pending");
    a_reads_accepted: assert property (@(posedge clk) disable iff (!reset_n)
        rdReady == 2'b11)
        else $error("read refused");
    a_wb_only_cause: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && !wbRequest && !(|alloc) |=> !wbValid)
        else $error("spontaneous write-back");
    a_sram_no_fill: assert property (@(posedge clk) disable iff (!reset_n)
        l1SramMode |-> fillValid == 2'b00)
        else $error("fill while level-one is SRAM");
    a_sram_flush: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && l1SramMode |=> dHit == 2'h0)
        else $error("level-one line kept in SRAM mode");
    a_no_snoop_l1: assert property (@(posedge clk) disable iff (!reset_n)
        dmaToL1 |-> !dNeedSnoop)
        else $error("snoop for level-one target");
endmodule
`default_nettype wire

// ---- dv/lsc_snoop_sink.sv ----
// Snoop-write sink model standing in for the level-one data RAM update path
`timescale 1ns/1ps
`default_nettype none
module lsc_snoop_sink (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       snoopValid,
    input  wire logic       stall,
    input  wire logic [3:0] lat,
    output logic            snoopDone
);
    logic [3:0] waitQ;
    logic [3:0] waitD;
    // Accept after lat cycles; stall keeps the write pending so kills can be provoked
    always_comb begin
        snoopDone = snoopValid && !stall && (waitQ >= lat);
        waitD     = (snoopValid && !snoopDone && !stall) ? waitQ + 4'h1 : 4'h0;
    end
    // Wait counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) waitQ <= 4'h0;
        else waitQ <= waitD;
    end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the snoop coherence core
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lsc_pkg::*;
    logic                clk, reset_n, l1SramMode, dmaValid, dmaToL1, dmaL2IsSram, stall;
    logic                snoopValid, snoopWay, snoopDone, cancelPulse, wbValid, dmaReady;
    logic                dmaL1Access, clkEn, wbRequest;
    lsc_l2mode_t         l2Mode;
    logic [1:0]          rdValid, rdL2CacheHit, rdReady, fillValid, fillWay;
    logic [2*ADDR_W-1:0] rdAddr;
    logic [ADDR_W-1:0]   dmaAddr, wbAddr;
    logic [3:0]          snoopSet, lat;
    int                  err_total, cmp_count;
    // Core and snoop sink
    lsc_snoop_core #(.SETS(16), .PEND(4)) uut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
        .l2Mode(l2Mode), .l1SramMode(l1SramMode), .rdValid(rdValid), .rdAddr(rdAddr),
        .rdL2CacheHit(rdL2CacheHit), .rdReady(rdReady), .fillValid(fillValid),
        .fillWay(fillWay), .dmaValid(dmaValid), .dmaAddr(dmaAddr), .dmaToL1(dmaToL1),
        .dmaL2IsSram(dmaL2IsSram), .dmaReady(dmaReady), .dmaL1Access(dmaL1Access),
        .snoopValid(snoopValid), .snoopSet(snoopSet), .snoopWay(snoopWay),
        .snoopDone(snoopDone), .cancelPulse(cancelPulse), .wbRequest(wbRequest),
        .wbValid(wbValid), .wbAddr(wbAddr));
    lsc_snoop_sink sink (.clk(clk), .reset_n(reset_n), .snoopValid(snoopValid),
        .stall(stall), .lat(lat), .snoopDone(snoopDone));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] ad(input int s, input int t);
        return 32'(t * 1024 + s * 64);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request drivers: change after the edge, sample once outputs settle
    task automatic rd(input logic [1:0] v, input logic [31:0] a0, input logic [31:0] a1);
        @(posedge clk);
        dmaValid <= 1'b0;
        rdValid <= v;
        rdL2CacheHit <= v;
        rdAddr <= {a1, a0};
        @(negedge clk);
    endtask
    task automatic dma(input logic [31:0] a);
        @(posedge clk);
        rdValid <= 2'h0;
        dmaValid <= 1'b1;
        dmaAddr <= a;
        @(negedge clk);
    endtask
    task automatic idle();
        @(posedge clk);
        rdValid <= 2'h0;
        dmaValid <= 1'b0;
        @(negedge clk);
    endtask
    task automatic t_line();
        rd(2'h3, ad(1, 1), ad(1, 2));
        chk(rdReady, 2'h3);
        chk(fillValid, 2'h3);
        chk(fillWay[0] ^ fillWay[1], 1'h1);
        rd(2'h3, ad(1, 1) + 63, ad(1, 2) + 64);
        chk(fillValid, 2'h2);
        idle();
        chk(wbValid, 1'h0);
        $display("test line done");
    endtask
    // Pending snoop killed by a double fill in the same set
    task automatic t_snoop();
        logic w;
        @(posedge clk);
        stall <= 1'b1;
        rd(2'h3, ad(3, 1), ad(3, 2));
        w = fillWay[0];
        dma(ad(3, 1) + 8);
        idle();
        chk(snoopValid, 1'h1);
        chk(snoopSet, 4'h3);
        chk(snoopWay, w);
        rd(2'h3, ad(3, 5), ad(3, 6));
        chk(cancelPulse, 1'h1);
        chk(snoopValid, 1'h0);
        idle();
        chk(snoopValid, 1'h0);
        dma(ad(3, 1));
        idle();
        chk(snoopValid, 1'h0);
        dma(ad(3, 5));
        idle();
        chk(snoopValid, 1'h1);
        @(posedge clk);
        stall <= 1'b0;
        lat <= 4'h3;
        for (int k = 0; k < 10 && snoopValid === 1'b1; k++) @(negedge clk);
        chk(snoopValid, 1'h0);
        $display("test snoop done");
    endtask
    // Each configuration against a freshly cached line; only the mixed baseline snoops
    task automatic t_modes();
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            l2Mode <= LSC_L2_MIXED;
            l1SramMode <= 1'b0;
            dmaToL1 <= 1'b0;
            lat <= 4'h1;
            rd(2'h1, ad(5, 1), ad(0, 0));
            @(posedge clk);
            rdValid <= 2'h0;
            l2Mode <= (i == 1) ? LSC_L2_CACHE : ((i == 2) ? LSC_L2_SRAM : LSC_L2_MIXED);
            l1SramMode <= (i == 3);
            dmaToL1 <= (i == 4);
            dma(ad(5, 1));
            chk(dmaL1Access, i == 4);
            idle();
            chk(snoopValid, i == 0);
            idle();
        end
        @(posedge clk);
        l2Mode <= LSC_L2_MIXED;
        l1SramMode <= 1'b0;
        dmaToL1 <= 1'b0;
        $display("test modes done");
    endtask
    // Fill every slot, see the fifth refused and held, then drain oldest first
    task automatic t_full();
        logic sent;
        sent = 1'b0;
        for (int i = 0; i < 5; i++) rd(2'h1, ad(8 + i, 1), ad(0, 0));
        @(posedge clk);
        stall <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            dma(ad(8 + i, 1));
            chk(dmaReady, i < 4);
        end
        @(posedge clk);
        stall <= 1'b0;
        lat <= 4'h0;
        // Refused request stays up until a slot frees; dropped only after its accepting edge
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            chk(snoopValid, 1'h1);
            chk(snoopSet, 8 + i);
            if (!sent && dmaReady === 1'b1) begin
                sent = 1'b1;
                @(posedge clk);
                dmaValid <= 1'b0;
            end
        end
        @(negedge clk);
        chk(snoopValid, 1'h0);
        $display("test full done");
    endtask
    // Software write-back, first frozen by a low clock enable, then registered once
    task automatic t_wb();
        @(posedge clk);
        clkEn <= 1'b0;
        wbRequest <= 1'b1;
        dmaAddr <= ad(4, 7) + 5;
        @(posedge clk);
        clkEn <= 1'b1;
        @(negedge clk);
        chk(wbValid, 1'h0);
        @(posedge clk);
        wbRequest <= 1'b0;
        @(negedge clk);
        chk(wbValid, 1'h1);
        chk(wbAddr, ad(4, 7));
        @(posedge clk);
        @(negedge clk);
        chk(wbValid, 1'h0);
        $display("test wb done");
    endtask
    task automatic print_verdict();
        $display("compares=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog, far beyond the fewer than a hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        print_verdict();
    end
    // Reset then scenarios
    initial begin
        reset_n = 1'b0;
        {l1SramMode, dmaValid, dmaToL1, stall, rdValid, rdL2CacheHit, wbRequest} = '0;
        clkEn = 1'b1;
        dmaL2IsSram = 1'b1;
        l2Mode = LSC_L2_MIXED;
        rdAddr = '0;
        dmaAddr = '0;
        lat = 4'h1;
        err_total = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_line();
        t_snoop();
        t_modes();
        t_full();
        t_wb();
        print_verdict();
    end
endmodule
`default_nettype wire
